// [src/spi_master_slave_core.sv]
`timescale 1ns/100ps
module spi_master_slave_core #(
    parameter int FIFO_WORDS = spi_core_pkg::FIFO_DEPTH
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire spi_core_pkg::cfg_s  cfg,
    input  wire logic                role_write,
    input  wire logic                role_value,
    output logic                     master_role,
    input  wire logic                done_irq_enable,
    input  wire logic                tx_finished_irq_enable,
    input  wire logic                global_irq_enable,
    input  wire spi_core_pkg::flag_s flag_clear,
    output spi_core_pkg::flag_s      flags,
    output logic                     irq,
    input  wire logic                wr_valid,
    output logic                     wr_ready,
    input  wire logic [7:0]          wr_data,
    input  wire logic                rd_req,
    output logic [7:0]               rd_data,
    output logic                     rd_valid,
    input  wire logic                sck_in,
    output logic                     sck_out,
    output logic                     sck_oe,
    input  wire logic                mosi_in,
    output logic                     mosi_out,
    output logic                     mosi_oe,
    input  wire logic                miso_in,
    output logic                     miso_out,
    output logic                     miso_oe,
    input  wire logic                ss_n_in
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Half period of the generated clock in peripheral cycles
    function automatic logic [7:0] half_period(input logic [1:0] sel,
                                               input logic       dbl);
        logic [7:0] d;
        d = spi_core_pkg::DIV_0;
        case (sel)
            2'h1:    d = spi_core_pkg::DIV_1;
            2'h2:    d = spi_core_pkg::DIV_2;
            2'h3:    d = spi_core_pkg::DIV_3;
            default: d = spi_core_pkg::DIV_0;
        endcase
        half_period = dbl ? (d >> 2) : (d >> 1);
    endfunction : half_period

    // Shift one bit in at the end opposite to the outgoing bit
    function automatic logic [7:0] shift_in(input logic [7:0] s,
                                            input logic       lsb_first,
                                            input logic       b);
        shift_in = lsb_first ? {b, s[7:1]} : {s[6:0], b};
    endfunction : shift_in

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sck_sync;
    logic [1:0] ss_sync;
    logic [1:0] mosi_sync;
    logic [1:0] miso_sync;
    logic       sck_prev;
    logic       ss_prev;

    // Two stages; only stage 1 is ever looked at
    always_ff @(posedge clk) begin
        sck_sync  <= {sck_sync[0], sck_in};
        ss_sync   <= {ss_sync[0], ss_n_in};
        mosi_sync <= {mosi_sync[0], mosi_in};
        miso_sync <= {miso_sync[0], miso_in};
        sck_prev  <= sck_sync[1];
        ss_prev   <= ss_sync[1];
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    spi_core_pkg::gen_e gen;
    logic [7:0] shreg;
    logic [7:0] hold;
    logic       hold_full;
    logic [7:0] rx_first;
    logic [7:0] rx_second;
    logic [1:0] rx_count;
    logic [3:0] bit_cnt;
    logic [7:0] tick_cnt;
    logic       busy;
    logic       tgt_loaded;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire ss_low      = !ss_sync[1];
    wire buffered    = cfg.buffering_on_bit;
    wire is_master   = cfg.enable && master_role;
    wire is_target   = cfg.enable && !master_role;
    // Ignore bit or output direction keep the pin out of the core
    wire ss_takeover = is_master && !cfg.select_pin_ignore_bit
                       && !cfg.ss_dir_out && ss_low;
    wire tick        = gen != spi_core_pkg::IDLE
                       && tick_cnt == half_period(cfg.clock_divider_field,
                                                  cfg.double_rate_bit) - 8'h01;
    // Sample at the falling tick: the synced data-in pin lags two cycles
    wire m_sample    = is_master && tick && gen == spi_core_pkg::CLK_HIGH;
    wire t_active    = is_target && ss_low;
    wire t_rise      = t_active && sck_sync[1] && !sck_prev;
    wire sample      = m_sample || t_rise;
    wire in_bit      = is_master ? miso_sync[1] : mosi_sync[1];
    wire [7:0] rx_byte = shift_in(shreg, cfg.bit_order_bit, in_bit);
    wire last_bit    = bit_cnt == spi_core_pkg::BITS_PER_BYTE - 4'h1;
    wire complete    = sample && last_bit;
    wire ss_rise     = is_target && ss_sync[1] && !ss_prev;

    // Drained write from the buffer; buffered mode stalls when holding full
    logic [7:0] fifo_data;
    logic       fifo_valid;
    wire        can_take = !buffered || !hold_full || (is_master && !busy);
    wire        dwr      = fifo_valid && can_take && cfg.enable;
    // Controller with idle shifter loads it directly and starts
    wire        direct   = dwr && (is_master ? !busy
                                  : (!buffered || (cfg.buffer_wait_rx_bit
                                     && !ss_low && !tgt_loaded)));
    wire        to_hold  = dwr && buffered && !direct;
    wire        clash    = dwr && !buffered && busy;
    wire        move_hold = complete && buffered && hold_full;

    // ----------------------------------------------------------------
    // Write buffer: 16 words ahead of the data port
    // ----------------------------------------------------------------
    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_WORDS)
    ) u_wr_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (fifo_valid),
        .out_ready (can_take && cfg.enable),
        .out_data  (fifo_data)
    );

    // ----------------------------------------------------------------
    // Role bit
    // ----------------------------------------------------------------
    // Hardware takeover wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst)
            master_role <= 1'b0;
        else if (ss_takeover)
            master_role <= 1'b0;
        else if (role_write)
            master_role <= role_value;
    end

    // ----------------------------------------------------------------
    // Clock generator and bit counter
    // ----------------------------------------------------------------
    // Abort on takeover, target deselect or disable drops the byte
    always_ff @(posedge clk) begin
        if (sys_rst || ss_takeover || ss_rise || !cfg.enable) begin
            gen      <= spi_core_pkg::IDLE;
            tick_cnt <= 8'h00;
            bit_cnt  <= 4'h0;
            busy     <= 1'b0;
            sck_out  <= 1'b0;
        end else begin
            tick_cnt <= (tick || gen == spi_core_pkg::IDLE) ? 8'h00
                                                            : tick_cnt + 8'h01;
            if (sample)
                bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
            if (is_target)
                busy <= complete ? 1'b0 : (sample ? 1'b1 : busy);
            case (gen)
                spi_core_pkg::IDLE: begin
                    if (is_master && direct) begin
                        gen  <= spi_core_pkg::CLK_LOW;
                        busy <= 1'b1;
                    end
                end
                spi_core_pkg::CLK_LOW: begin
                    if (tick) begin
                        gen     <= spi_core_pkg::CLK_HIGH;
                        sck_out <= 1'b1;
                    end
                end
                spi_core_pkg::CLK_HIGH: begin
                    if (tick) begin
                        sck_out <= 1'b0;
                        // Held byte follows without a gap
                        if (last_bit && !hold_full) begin
                            gen  <= spi_core_pkg::IDLE;
                            busy <= 1'b0;
                        end else begin
                            gen <= spi_core_pkg::CLK_LOW;
                        end
                    end
                end
                default: gen <= spi_core_pkg::IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Shift register and holding register
    // ----------------------------------------------------------------
    // Target in wait-rx variant preloads shifter while deselected
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shreg      <= spi_core_pkg::RESET_BYTE;
            hold       <= spi_core_pkg::RESET_BYTE;
            hold_full  <= 1'b0;
            tgt_loaded <= 1'b0;
        end else begin
            if (sample)
                shreg <= rx_byte;
            if (move_hold) begin
                shreg     <= hold;
                hold_full <= 1'b0;
            end else if (to_hold) begin
                hold      <= fifo_data;
                hold_full <= 1'b1;
            end
            if (direct && !clash)
                shreg <= fifo_data;
            if (complete || ss_rise)
                tgt_loaded <= 1'b0;
            else if (direct && is_target)
                tgt_loaded <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Receive buffers
    // ----------------------------------------------------------------
    // Second slot only used when buffered; a third byte is dropped
    wire pop = rd_req && buffered && rx_count != 2'h0;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_first  <= spi_core_pkg::RESET_BYTE;
            rx_second <= spi_core_pkg::RESET_BYTE;
            rx_count  <= 2'h0;
        end else if (!buffered) begin
            rx_count <= 2'h0;
            if (complete)
                rx_first <= rx_byte;
        end else begin
            if (pop)
                rx_first <= rx_second;
            if (complete) begin
                if (rx_count == 2'h0 || (rx_count == 2'h1 && pop))
                    rx_first <= rx_byte;
                else if (rx_count - 2'(pop) == 2'h1)
                    rx_second <= rx_byte;
            end
            if (complete && !(rx_count == 2'h2 && !pop))
                rx_count <= rx_count + 2'h1 - 2'(pop);
            else
                rx_count <= rx_count - 2'(pop);
        end
    end

    // Read answer, one cycle after the request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data  <= spi_core_pkg::RESET_BYTE;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req)
                rd_data <= rx_first;
        end
    end

    // ----------------------------------------------------------------
    // Flags: hardware set wins over clear in the same cycle
    // ----------------------------------------------------------------
    wire hold_empty_now = !(hold_full || to_hold) || move_hold;
    wire finished_now   = buffered && complete && !hold_full;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= '0;
            flags.tx_holding_empty_flag <= 1'b1;
        end else begin
            flags.transfer_done_flag <= (complete && !buffered)
                                        || ss_takeover
                                        || (flags.transfer_done_flag
                                            && !flag_clear.transfer_done_flag);
            flags.write_clash_flag   <= clash
                                        || (flags.write_clash_flag
                                            && !flag_clear.write_clash_flag);
            flags.tx_holding_empty_flag <= hold_empty_now;
            flags.tx_finished_flag   <= finished_now
                                        || (flags.tx_finished_flag
                                            && !flag_clear.tx_finished_flag);
        end
    end

    // Interrupt request, gated by its enables and the global enable
    always_ff @(posedge clk) begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= global_irq_enable
                   && ((flags.transfer_done_flag && done_irq_enable)
                       || (flags.tx_finished_flag && tx_finished_irq_enable));
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // Outgoing bit is the end of the shifter selected by bit order
    wire out_bit = cfg.bit_order_bit ? shreg[0] : shreg[7];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mosi_out <= 1'b0;
            miso_out <= 1'b0;
            sck_oe   <= 1'b0;
            mosi_oe  <= 1'b0;
            miso_oe  <= 1'b0;
        end else begin
            mosi_out <= out_bit;
            miso_out <= out_bit;
            sck_oe   <= is_master;
            mosi_oe  <= is_master;
            miso_oe  <= t_active && cfg.miso_dir_out;
        end
    end

endmodule : spi_master_slave_core

// [src/spi_core_pkg.sv]
package spi_core_pkg;

    // -------------------------------------------------------------
    // Clock divider, byte length, buffer depth and reset byte
    // -------------------------------------------------------------
    localparam logic [7:0] DIV_0 = 8'h04;
    localparam logic [7:0] DIV_1 = 8'h10;
    localparam logic [7:0] DIV_2 = 8'h40;
    localparam logic [7:0] DIV_3 = 8'h80;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int         FIFO_DEPTH = 16;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // -------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic [1:0] clock_divider_field;
        logic       double_rate_bit;
        logic       bit_order_bit;
        logic       buffering_on_bit;
        logic       buffer_wait_rx_bit;
        logic       select_pin_ignore_bit;
        logic       ss_dir_out;
        logic       miso_dir_out;
    } cfg_s;

    typedef struct packed {
        logic transfer_done_flag;
        logic write_clash_flag;
        logic tx_holding_empty_flag;
        logic tx_finished_flag;
    } flag_s;

    typedef enum logic [1:0] {
        IDLE,
        CLK_LOW,
        CLK_HIGH
    } gen_e;

endpackage : spi_core_pkg

// [src/byte_fifo.sv]
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // Empty from the count; full is registered so the ready port is a flop
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid  = count != '0;
    assign out_data   = mem[rd_ptr];

    // Pointer and storage update
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count    <= next_count;
            in_ready <= next_count != (AW+1)'(DEPTH);
        end
    end
endmodule : byte_fifo

// [verification/spi_peer_model.sv]
`timescale 1ns/100ps
// ---
// Far-side target peer: mode 0, MSB first
// ---
module spi_peer_model (
    input  wire logic  sck,
    input  wire logic  mosi,
    input  wire logic  sel,
    output logic       miso,
    output logic [7:0] rx,
    output logic [7:0] count
);
    logic [7:0] sh = 8'h50;
    logic [7:0] rin = 8'h00;
    logic [2:0] n = 3'h0;
    // Unselected line shows the inverse, so a stale bit never passes
    assign miso = sel ? sh[7] : ~sh[7];
    initial begin
        rx = 8'h00;
        count = 8'h00;
    end
    // Sample on rise, shift on fall; byte k sent is 0x50 plus k
    always @(posedge sck) begin
        rin <= {rin[6:0], mosi};
        n <= n + 3'h1;
        if (n == 3'h7) begin
            rx <= {rin[6:0], mosi};
            count <= count + 8'h01;
        end
    end
    always @(negedge sck) begin
        if (n == 3'h0) sh <= 8'h50 + count;
        else sh <= {sh[6:0], 1'h0};
    end
endmodule : spi_peer_model

// [verification/spi_master_slave_core_chk.sv]
`timescale 1ns/100ps
// ---
// Port checker
// ---
module spi_master_slave_core_chk (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire spi_core_pkg::cfg_s  cfg,
    input wire logic                role_write,
    input wire logic                master_role,
    input wire logic                global_irq_enable,
    input wire spi_core_pkg::flag_s flags,
    input wire logic                irq,
    input wire logic                wr_valid,
    input wire logic                wr_ready,
    input wire logic                sck_out,
    input wire logic                sck_oe,
    input wire logic                mosi_oe,
    input wire logic                miso_oe,
    input wire logic                ss_n_in
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Select pins pass two sync flops, so allow three cycles
    sequence s_take;
        cfg.enable && master_role && !role_write && !cfg.select_pin_ignore_bit
            && !cfg.ss_dir_out && !ss_n_in;
    endsequence
    sequence s_sel;
        cfg.enable && !master_role && cfg.miso_dir_out && !ss_n_in;
    endsequence
    sequence s_pulse;
        sck_out ##1 sck_out ##1 !sck_out;
    endsequence
    property p_take;
        s_take[*3] |=> !master_role;
    endproperty
    a_take: assert property (p_take) else $error("role kept with select low");
    property p_keep;
        master_role && !role_write && (cfg.select_pin_ignore_bit || cfg.ss_dir_out)
            |=> master_role;
    endproperty
    a_keep: assert property (p_keep) else $error("role lost");
    property p_miso_off;
        ss_n_in[*4] |-> !miso_oe;
    endproperty
    a_miso_off: assert property (p_miso_off) else $error("miso driven");
    property p_miso_on;
        s_sel[*4] |-> miso_oe;
    endproperty
    a_miso_on: assert property (p_miso_on) else $error("miso not driven");
    property p_pins_in;
        !master_role[*2] |-> !sck_oe && !mosi_oe;
    endproperty
    a_pins_in: assert property (p_pins_in) else $error("target drives pins");
    property p_irq_off;
        !global_irq_enable[*2] |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while masked");
    property p_half;
        master_role && cfg.clock_divider_field == 2'h0 && !cfg.double_rate_bit
            && $rose(sck_out) |-> s_pulse;
    endproperty
    a_half: assert property (p_half) else $error("sck half period");
    property p_start;
        master_role && cfg.enable && cfg.clock_divider_field == 2'h0 && wr_valid
            && wr_ready |-> ##[1:12] $rose(sck_out);
    endproperty
    a_start: assert property (p_start) else $error("no sck after write");
endmodule : spi_master_slave_core_chk

// [verification/spi_master_slave_core_tb.sv]
`timescale 1ns/100ps
module spi_master_slave_core_tb;
    logic clk, sys_rst, role_write, role_value, master_role, dirq, tirq, girq, irq;
    logic wr_valid, wr_ready, rd_req, rd_valid, sck_in, sck_out, sck_oe, ss_n_in;
    logic mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
    logic [7:0] wr_data, rd_data, prx, pcnt, m;
    logic [3:0] fv;
    int errors, compares;
    spi_core_pkg::cfg_s cfg;
    spi_core_pkg::flag_s flag_clear, flags;
    assign fv = flags;
    spi_master_slave_core #(.FIFO_WORDS(16)) u_dut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
        .role_write(role_write), .role_value(role_value), .master_role(master_role),
        .done_irq_enable(dirq), .tx_finished_irq_enable(tirq), .global_irq_enable(girq),
        .flag_clear(flag_clear), .flags(flags), .irq(irq), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rd_req(rd_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in),
        .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
    spi_peer_model u_peer (.sck(sck_out), .mosi(mosi_out), .sel(sck_oe), .miso(miso_in),
        .rx(prx), .count(pcnt));
    // ---
    // Tasks
    // ---
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] b);
        int i;
        @(negedge clk);
        wr_valid = 1'h1;
        wr_data = b;
        for (i = 0; i < 200 && wr_ready !== 1'h1; i++) @(negedge clk);
        @(negedge clk);
        wr_valid = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] exp);
        @(negedge clk);
        rd_req = 1'h1;
        @(negedge clk);
        rd_req = 1'h0;
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, exp);
    endtask : rd
    // Bounded wait on one flag; a timeout shows as a mismatch
    task automatic wt(input int b);
        int i;
        for (i = 0; i < 20000 && fv[b] !== 1'h1; i++) @(negedge clk);
        chk({7'h00, fv[b]}, 8'h01);
    endtask : wt
    task automatic clr;
        @(negedge clk);
        flag_clear = 4'hf;
        @(negedge clk);
        flag_clear = 4'h0;
    endtask : clr
    // Remote controller at 125 ns, phases far above two cycles
    task automatic sx(input logic [7:0] b, input int n);
        int i;
        ss_n_in = 1'h0;
        for (i = 0; i < n; i++) begin
            mosi_in = b[7 - i];
            #62.5;
            m = {m[6:0], miso_out};
            sck_in = 1'h1;
            #62.5;
            sck_in = 1'h0;
        end
        #62.5;
        mosi_in = ~mosi_in;
        ss_n_in = 1'h1;
        #250;
    endtask : sx
    // ---
    // Clock, watchdog, sequence
    // ---
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500000;
        errors++;
        results;
    end
    initial begin
        {sys_rst, dirq, tirq, girq, ss_n_in} = 5'h1f;
        {role_write, role_value, wr_valid, rd_req, sck_in, mosi_in} = 6'h00;
        {wr_data, m, cfg, flag_clear} = '0;
        repeat (12) @(negedge clk);
        sys_rst = 1'h0;
        role_write = 1'h1;
        role_value = 1'h1;
        @(negedge clk);
        role_write = 1'h0;
        cfg.enable = 1'h1;
        chk({7'h00, master_role}, 8'h01);
        wr(8'h3c);
        wt(3);
        @(negedge clk);
        chk(prx, 8'h3c);
        chk({7'h00, irq}, 8'h01);
        rd(8'h50);
        clr;
        wr(8'h11);
        wr(8'h22);
        wt(3);
        chk({7'h00, fv[2]}, 8'h01);
        rd(8'h51);
        $display("normal controller test done");
        clr;
        cfg.bit_order_bit = 1'h1;
        wr(8'h01);
        wt(3);
        chk(prx, 8'h80);
        rd(8'h4a);
        clr;
        cfg.bit_order_bit = 1'h0;
        {cfg.clock_divider_field, cfg.double_rate_bit} = 3'h7;
        wr(8'h7e);
        wt(3);
        chk(prx, 8'h7e);
        rd(8'h53);
        $display("clock and order test done");
        {cfg.clock_divider_field, cfg.double_rate_bit} = 3'h0;
        clr;
        girq = 1'h0;
        {cfg.buffering_on_bit, cfg.buffer_wait_rx_bit} = 2'h3;
        wr(8'ha1);
        wr(8'ha2);
        wr(8'ha3);
        wt(0);
        chk(pcnt, 8'h07);
        chk(prx, 8'ha3);
        chk({6'h00, fv[1], fv[3]}, 8'h02);
        rd(8'h54);
        rd(8'h55);
        // Slow drain so the word buffer fills and refuses
        clr;
        cfg.clock_divider_field = 2'h3;
        wr_valid = 1'h1;
        wr_data = 8'hc3;
        repeat (24) @(negedge clk);
        chk({7'h00, wr_ready}, 8'h00);
        wr_valid = 1'h0;
        wt(0);
        rd(8'h57);
        rd(8'h58);
        $display("buffered test done");
        {cfg.buffering_on_bit, cfg.buffer_wait_rx_bit, cfg.clock_divider_field} = 4'h0;
        clr;
        girq = 1'h1;
        cfg.select_pin_ignore_bit = 1'h1;
        ss_n_in = 1'h0;
        repeat (10) @(negedge clk);
        chk({7'h00, master_role}, 8'h01);
        {cfg.select_pin_ignore_bit, cfg.ss_dir_out} = 2'h1;
        repeat (10) @(negedge clk);
        chk({7'h00, master_role}, 8'h01);
        // Select falls while the pin is an input: the pin-side takeover path
        ss_n_in = 1'h1;
        cfg.ss_dir_out = 1'h0;
        repeat (4) @(negedge clk);
        ss_n_in = 1'h0;
        repeat (10) @(negedge clk);
        chk({6'h00, master_role, fv[3]}, 8'h01);
        $display("takeover test done");
        ss_n_in = 1'h1;
        cfg.miso_dir_out = 1'h1;
        clr;
        wr(8'h96);
        repeat (5) @(negedge clk);
        sx(8'h3a, 8);
        wt(3);
        chk(m, 8'h96);
        rd(8'h3a);
        sx(8'hff, 3);
        sx(8'h5a, 8);
        rd(8'h5a);
        $display("target test done");
        results;
    end
endmodule : spi_master_slave_core_tb
bind spi_master_slave_core spi_master_slave_core_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .cfg(cfg), .role_write(role_write), .master_role(master_role),
    .global_irq_enable(global_irq_enable), .flags(flags), .irq(irq), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .ss_n_in(ss_n_in));
